// ==== rtl/binary_command_frame_parser.sv ====
// Purpose: decode binary read/write command frames into register accesses
// Assumes: rx bytes arrive with rx_valid; tx waits on tx_ready
// Notes: address lengths 2, 4, 6 and 8 bytes all accepted; upper bits zeroed at each start byte
// What this block does
// (R1) frame begins with start byte 0x01
// (R2) frame closes with end byte 0x03
// (R3) opcode is type byte bits 7..3
// (R4) opcode 00001 means single read
// (R5) opcode 00000 means single write
// (R6) type bit 2 flags check byte
// (R7) length code 00 means 16-bit address
// (R8) every address length code accepted correctly
// (R9) read length gives response byte count
// (R10) write length delimits the data bytes
// (R11) address assembled least significant byte first
// (R12) check byte is XOR of fields
// (R13) host sets check bit per frame
// (R14) field address is base plus offset
// (R15) frame bytes follow fixed order
// (R16) answer ACK 0x06 or NAK 0x15
// (R17) half second gap discards until start
// (R18) validate order, check, length before ACK
// (R19) unknown read address: ACK, no response
// (R20) write data stored lowest byte first
// (R21) read response framed like requests
`timescale 1ns/1ps
`default_nettype none
module binary_command_frame_parser
    import frame_parser_pkg::*;
#(
    parameter longint TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [63:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_addr_ok,
    output logic byte_timeout,
    output logic frame_error
);
    parse_state_t state_q, state_d;
    logic [7:0] type_q, type_d, len_q, len_d, chk_q, chk_d, tx_q, tx_d;
    logic [8:0] cnt_q, cnt_d;
    logic [63:0] addr_q, addr_d;
    logic [27:0] gap_q, gap_d;
    logic bad_q, bad_d, txv_q, txv_d, to_q, to_d, err_q, err_d;
    logic wr_q, wr_d, rd_q, rd_d;
    logic [7:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic [7:0] sel_byte;
    logic sel_last;

    function automatic logic [3:0] addr_bytes(input logic [1:0] code);
        // codes 0..3 give 2, 4, 6 and 8 address bytes
        return {1'b0, code[ALEN_MSB:0], 1'b0} + 4'h2; // R7 R8
    endfunction

    resp_byte_sel u_sel (
        .idx(cnt_q),
        .len(len_q),
        .check_on(type_q[CHECK_BIT]),
        .data_byte(rdat_q),
        .check_acc(chk_q),
        .byte_out(sel_byte),
        .last(sel_last)
    );

    always_comb begin
        state_d = state_q;
        type_d = type_q;
        len_d = len_q;
        chk_d = chk_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        bad_d = bad_q;
        tx_d = tx_q;
        txv_d = txv_q;
        to_d = 1'b0;
        err_d = 1'b0;
        wr_d = 1'b0;
        rd_d = 1'b0;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        gap_d = gap_q;
        if (txv_q && tx_ready) begin
            txv_d = 1'b0;
        end
        // gap counter runs only inside a request frame
        if (state_q inside {ST_TYPE, ST_LEN, ST_ADDR, ST_DATA, ST_CHECK, ST_END}) begin
            gap_d = rx_valid ? TIMEOUT_RESET : gap_q + 28'h0000001;
            if (!rx_valid && 64'(gap_q) >= 64'(TIMEOUT_LIMIT)) begin
                state_d = ST_DISCARD; // R17
                to_d = 1'b1;
            end
        end else begin
            gap_d = TIMEOUT_RESET;
        end
        case (state_q)
            ST_IDLE, ST_DISCARD: begin
                if (rx_valid && rx_data == FRAME_START_BYTE) begin
                    state_d = ST_TYPE; // R1
                    chk_d = 8'h00;
                    bad_d = 1'b0;
                    addr_d = ADDR_RESET;
                end else if (rx_valid && state_q == ST_IDLE) begin
                    state_d = ST_DISCARD; // stray bytes without start
                    err_d = 1'b1;
                end
            end
            ST_TYPE: if (rx_valid) begin
                type_d = rx_data;
                chk_d = chk_q ^ rx_data; // R12
                if (!(rx_data[OP_MSB:OP_LSB] inside {OP_READ, OP_WRITE})) begin
                    bad_d = 1'b1; // R3 R4 R5
                end
                state_d = ST_LEN; // R15
            end
            ST_LEN: if (rx_valid) begin
                len_d = rx_data; // R9 R10
                chk_d = chk_q ^ rx_data;
                cnt_d = 9'h000;
                state_d = ST_ADDR;
            end
            ST_ADDR: if (rx_valid) begin
                addr_d[cnt_q[2:0]*8 +: 8] = rx_data; // R11 R14
                chk_d = chk_q ^ rx_data;
                cnt_d = cnt_q + 9'h001;
                if (cnt_q[3:0] + 4'h1 == addr_bytes(type_q[1:0])) begin
                    cnt_d = 9'h000;
                    if (type_q[OP_MSB:OP_LSB] == OP_WRITE && len_q != 8'h00) begin
                        state_d = ST_DATA; // R5
                    end else begin
                        state_d = type_q[CHECK_BIT] ? ST_CHECK : ST_END; // R6
                    end
                end
            end
            ST_DATA: if (rx_valid) begin
                // write lands as it arrives; a bad frame still NAKs afterwards
                wr_d = 1'b1; // R20
                wdat_d = rx_data;
                chk_d = chk_q ^ rx_data;
                cnt_d = cnt_q + 9'h001;
                if (cnt_q + 9'h001 == 9'(len_q)) begin
                    state_d = type_q[CHECK_BIT] ? ST_CHECK : ST_END; // R10
                end
            end
            ST_CHECK: if (rx_valid) begin
                if (rx_data != chk_q) begin
                    bad_d = 1'b1; // R12 R18
                end
                state_d = ST_END;
            end
            ST_END: if (rx_valid && !txv_q) begin
                // a wrong end byte means data count or order was off
                bad_d = bad_q | (rx_data != FRAME_END_BYTE); // R2 R18
                tx_d = (bad_q || rx_data != FRAME_END_BYTE) ? NAK_BYTE : ACK_BYTE; // R16
                txv_d = 1'b1;
                err_d = bad_q || rx_data != FRAME_END_BYTE;
                state_d = ST_ACK;
            end
            ST_ACK: if (!txv_q || tx_ready) begin
                txv_d = 1'b0;
                cnt_d = 9'h000;
                chk_d = 8'h00;
                if (!bad_q && type_q[OP_MSB:OP_LSB] == OP_READ && len_q != 8'h00
                        && reg_addr_ok) begin
                    state_d = ST_READ; // R19
                    rd_d = 1'b1;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_READ: begin
                rdat_d = reg_rdata;
                state_d = ST_RESP;
            end
            ST_RESP: if (!txv_q || tx_ready) begin
                tx_d = sel_byte; // R21
                txv_d = 1'b1;
                cnt_d = cnt_q + 9'h001;
                if (cnt_q != 9'h000) begin
                    chk_d = chk_q ^ sel_byte; // R12
                end
                if (sel_last) begin
                    state_d = ST_IDLE;
                end else if (cnt_q >= 9'h003 && cnt_q < 9'(len_q) + 9'h002) begin
                    // next read only once a data byte is out, else bytes skip
                    addr_d = addr_q + 64'h1; // R20
                    rd_d = 1'b1;
                    state_d = ST_READ;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (wr_q) begin
            addr_d = addr_q + 64'h1; // R20
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            type_q <= 8'h00;
            len_q <= 8'h00;
            chk_q <= 8'h00;
            cnt_q <= 9'h000;
            addr_q <= ADDR_RESET;
            gap_q <= TIMEOUT_RESET;
            bad_q <= 1'b0;
            tx_q <= 8'h00;
            txv_q <= 1'b0;
            to_q <= 1'b0;
            err_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wdat_q <= 8'h00;
            rdat_q <= 8'h00;
        end else begin
            state_q <= state_d;
            type_q <= type_d;
            len_q <= len_d;
            chk_q <= chk_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            gap_q <= gap_d;
            bad_q <= bad_d;
            tx_q <= tx_d;
            txv_q <= txv_d;
            to_q <= to_d;
            err_q <= err_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
        end
    end

    assign tx_data = tx_q;
    assign tx_valid = txv_q;
    assign reg_addr = addr_q;
    assign reg_wdata = wdat_q;
    assign reg_write = wr_q;
    assign reg_read = rd_q;
    assign byte_timeout = to_q;
    assign frame_error = err_q;

    sequence s_start;
        state_q inside {ST_IDLE, ST_DISCARD} && rx_valid && rx_data == FRAME_START_BYTE;
    endsequence

    a_start_opens_frame: assert property (@(posedge clk) disable iff (!rst_n) // R1
        s_start |=> state_q == ST_TYPE) else $error("start byte did not open frame");
    a_end_nak: assert property (@(posedge clk) disable iff (!rst_n) // R2
        state_q == ST_END && rx_valid && !txv_q && rx_data != FRAME_END_BYTE
        |=> tx_valid && tx_data == NAK_BYTE) else $error("bad end byte not refused");
    a_bad_opcode: assert property (@(posedge clk) disable iff (!rst_n) // R3
        state_q == ST_TYPE && rx_valid && rx_data[7:4] != 4'h0 |=> bad_q)
        else $error("bad opcode accepted");
    a_read_issue: assert property (@(posedge clk) disable iff (!rst_n) // R4
        state_q == ST_ACK && tx_ready && !bad_q && type_q[7:3] == OP_READ && len_q != 8'h00
        && reg_addr_ok |=> reg_read) else $error("read not issued");
    a_write_data: assert property (@(posedge clk) disable iff (!rst_n) // R5
        state_q == ST_DATA && rx_valid |=> reg_write && reg_wdata == $past(rx_data))
        else $error("write byte lost");
    a_check_route: assert property (@(posedge clk) disable iff (!rst_n) // R6
        state_q == ST_ADDR && rx_valid && type_q[1:0] == 2'b00 && cnt_q == 9'h001
        && type_q[7:3] == OP_READ && type_q[2] |=> state_q == ST_CHECK)
        else $error("check byte not expected");
    a_addr_le: assert property (@(posedge clk) disable iff (!rst_n) // R11
        state_q == ST_ADDR && rx_valid && cnt_q == 9'h001 |=> reg_addr[15:8] == $past(rx_data))
        else $error("address byte order wrong");
    a_check_nak: assert property (@(posedge clk) disable iff (!rst_n) // R12
        state_q == ST_CHECK && rx_valid && rx_data != chk_q |=> bad_q)
        else $error("check mismatch missed");
    a_timeout: assert property (@(posedge clk) disable iff (!rst_n) // R17
        byte_timeout |-> state_q == ST_DISCARD) else $error("timeout did not discard");
    a_no_resp: assert property (@(posedge clk) disable iff (!rst_n) // R19
        state_q == ST_ACK && !reg_addr_ok && (!txv_q || tx_ready) |=> state_q == ST_IDLE)
        else $error("response for unknown address");
endmodule
`default_nettype wire

// ==== shared/frame_parser_pkg.sv ====
// Purpose: constants and types for the binary command frame parser
// Assumes: one 250 MHz clock, byte stream with valid/ready
// Notes: register access leaves the block as a plain request/answer port
package frame_parser_pkg;
    localparam logic [7:0] FRAME_START_BYTE = 8'h01;
    localparam logic [7:0] FRAME_END_BYTE = 8'h03;
    localparam logic [7:0] ACK_BYTE = 8'h06;
    localparam logic [7:0] NAK_BYTE = 8'h15;
    localparam logic [4:0] OP_WRITE = 5'h00;
    localparam logic [4:0] OP_READ = 5'h01;
    localparam logic [4:0] OP_READ_RESP = 5'h02;
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 3;
    localparam int CHECK_BIT = 2;
    localparam int ALEN_MSB = 1;
    localparam int ADDR_BYTES_MAX = 8;
    localparam int CLK_MHZ = 250;
    localparam int BYTE_TIMEOUT_MS = 500;
    localparam longint TIMEOUT_CYCLES = longint'(BYTE_TIMEOUT_MS) * 1000 * CLK_MHZ;
    localparam logic [27:0] TIMEOUT_RESET = 28'h0000000;
    localparam logic [63:0] ADDR_RESET = 64'h0000000000000000;
    typedef enum logic [3:0] {
        ST_IDLE, ST_TYPE, ST_LEN, ST_ADDR, ST_DATA, ST_CHECK, ST_END,
        ST_DISCARD, ST_ACK, ST_READ, ST_RESP
    } parse_state_t;
endpackage

// ==== rtl/resp_byte_sel.sv ====
// Purpose: picks the next byte of a read response frame
// Assumes: index counts frame bytes from the start byte
// Notes: combinational, read by the parser only
`timescale 1ns/1ps
`default_nettype none
module resp_byte_sel
    import frame_parser_pkg::*;
(
    input wire logic [8:0] idx,
    input wire logic [7:0] len,
    input wire logic check_on,
    input wire logic [7:0] data_byte,
    input wire logic [7:0] check_acc,
    output logic [7:0] byte_out,
    output logic last
);
    logic [8:0] data_end;
    always_comb begin
        data_end = 9'(len) + 9'h003;
        last = 1'b0;
        if (idx == 9'h000) begin
            byte_out = FRAME_START_BYTE;
        end else if (idx == 9'h001) begin
            byte_out = {OP_READ_RESP, check_on, 2'b00};
        end else if (idx == 9'h002) begin
            byte_out = len;
        end else if (idx < data_end) begin
            byte_out = data_byte;
        end else if (check_on && idx == data_end) begin
            byte_out = check_acc;
        end else begin
            byte_out = FRAME_END_BYTE;
            last = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== bench/host_link_model.sv ====
// Purpose: host end of the serial link, builds frames and collects replies
// Assumes: parser inputs change on the falling edge
// Notes: between bytes rx_data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    input wire logic clk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] got[$];
    bit slow = 1'b0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    // slow mode accepts every other cycle to stall the reply path
    always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
    // one byte per two cycles, line scrambled after, so stale data never passes
    task automatic put(input logic [7:0] b);
        @(negedge clk);
        rx_data = b;
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data = ~b;
    endtask
    task automatic frame(input logic [7:0] ft, input logic [7:0] len, input logic [63:0] a,
        input logic [7:0] d0, input bit bad);
        logic [7:0] x;
        int na;
        na = 2 * (ft[1:0] + 1);
        x = ft ^ len;
        put(8'h01);
        put(ft);
        put(len);
        for (int i = 0; i < na; i++) begin
            put(a[8*i +: 8]);
            x ^= a[8*i +: 8];
        end
        if (ft[7:3] == 5'h00) begin
            for (int i = 0; i < len; i++) begin
                put(d0 + 8'(i));
                x ^= d0 + 8'(i);
            end
        end
        if (ft[2]) put(bad ? ~x : x);
        put(8'h03);
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for the command frame parser
// Assumes: host link model drives rx, bench models the register side
// Notes: timeout limit cut to 50 cycles to keep the run short
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import frame_parser_pkg::*;
    typedef struct {
        logic [7:0] ft;
        logic [7:0] len;
        logic [63:0] a;
        logic [7:0] d0;
        bit bad;
        logic [7:0] ack;
    } row_t;
    logic clk = 1'b0;
    logic rst_n;
    logic [7:0] rx_data, tx_data, reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_addr_ok;
    logic rx_valid, tx_valid, tx_ready, reg_write, reg_read, byte_timeout, frame_error;
    logic [63:0] reg_addr;
    logic [7:0] mem [256];
    logic [7:0] e[$];
    int mismatches = 0;
    int checks = 0;
    int n_tmo = 0;
    int n_err = 0;
    row_t rows [8] = '{
        '{8'h00, 8'h01, 64'h1801, 8'h3C, 1'b0, ACK_BYTE},
        '{8'h05, 8'h02, 64'h1802, 8'h50, 1'b0, ACK_BYTE},
        '{8'h07, 8'h01, 64'h1810, 8'h77, 1'b1, NAK_BYTE},
        '{8'h0E, 8'h02, 64'h1801, 8'h00, 1'b0, ACK_BYTE},
        '{8'h0B, 8'h01, 64'h2000, 8'h00, 1'b0, ACK_BYTE},
        '{8'h0C, 8'h00, 64'h1800, 8'h00, 1'b0, ACK_BYTE},
        '{8'h0C, 8'h01, 64'h1800, 8'h00, 1'b0, ACK_BYTE},
        '{8'h18, 8'h01, 64'h1801, 8'h00, 1'b0, NAK_BYTE}};
    always #2 clk = ~clk;
    binary_command_frame_parser #(.TIMEOUT_LIMIT(50)) u_binary_command_frame_parser (
        .clk(clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_addr_ok(reg_addr_ok),
        .byte_timeout(byte_timeout), .frame_error(frame_error));
    host_link_model u_host_link_model (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    // register side: only page 0x18 exists, read data half a cycle after the strobe, on the falling edge
    always @(negedge clk) begin
        reg_addr_ok <= reg_addr[63:8] == 56'h18;
        // scrambled when no read, so a late sample shows up as a mismatch
        reg_rdata <= reg_read ? mem[reg_addr[7:0]] : ~mem[reg_addr[7:0]];
        if (reg_write && reg_addr[63:8] == 56'h18) mem[reg_addr[7:0]] <= reg_wdata;
    end
    always @(posedge clk) begin
        if (byte_timeout === 1'b1) n_tmo++;
        if (frame_error === 1'b1) n_err++;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for the bytes, then a quiet spell to catch extra ones
    task automatic expect_tx();
        int k;
        k = 0;
        while (u_host_link_model.got.size() < e.size() && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (u_host_link_model.got.size() < e.size()) begin
            mismatches++;
            $display("[ERR] tx wait expected %0d seen %0d", e.size(), u_host_link_model.got.size());
            test_done();
        end
        repeat (80) @(negedge clk);
        check8("tx count", 8'(e.size()), 8'(u_host_link_model.got.size()));
        foreach (e[i]) check8("tx byte", e[i], u_host_link_model.got[i]);
        u_host_link_model.got.delete();
    endtask
    task automatic run_row(input row_t r);
        logic [7:0] t;
        logic [7:0] x;
        u_host_link_model.frame(r.ft, r.len, r.a, r.d0, r.bad);
        e = '{r.ack};
        t = {OP_READ_RESP, r.ft[2], 2'b00};
        if (r.ft[7:3] == OP_READ && r.len != 0 && r.a[63:8] == 56'h18) begin
            x = t ^ r.len;
            e = {e, 8'h01, t, r.len};
            for (int i = 0; i < r.len; i++) begin
                e.push_back(mem[r.a[7:0] + 8'(i)]);
                x ^= mem[r.a[7:0] + 8'(i)];
            end
            if (t[2]) e.push_back(x);
            e.push_back(8'h03);
        end
        expect_tx();
        if (r.ft[7:3] == OP_WRITE && !r.bad) begin
            for (int i = 0; i < r.len; i++) begin
                check8("mem", r.d0 + 8'(i), mem[r.a[7:0] + 8'(i)]);
            end
        end
    endtask
    initial begin
        rst_n = 1'b0;
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        check8("tx_valid", 8'h00, {7'h00, tx_valid});
        check8("reg_addr", 8'h00, reg_addr[7:0]);
        foreach (rows[r]) begin
            u_host_link_model.slow = r[0];
            run_row(rows[r]);
        end
        // stray byte with no start is dropped and flagged
        n_err = 0;
        u_host_link_model.put(8'h55);
        e = {};
        expect_tx();
        check8("stray flag", 8'h01, 8'(n_err));
        // long gap in mid-frame, trailing end byte must be ignored
        n_tmo = 0;
        u_host_link_model.put(8'h01);
        u_host_link_model.put(8'h04);
        repeat (60) @(negedge clk);
        u_host_link_model.put(8'h03);
        expect_tx();
        check8("timeouts", 8'h01, 8'(n_tmo));
        run_row(rows[6]);
        // wrong closing byte: length 0 write, data byte sits where the end should be
        n_err = 0;
        u_host_link_model.put(8'h01);
        u_host_link_model.put(8'h00);
        u_host_link_model.put(8'h00);
        u_host_link_model.put(8'h00);
        u_host_link_model.put(8'h18);
        u_host_link_model.put(8'h55);
        e = '{NAK_BYTE};
        expect_tx();
        check8("end flag", 8'h01, 8'(n_err));
        // reset in mid-frame leaves nothing pending
        u_host_link_model.put(8'h01);
        u_host_link_model.put(8'h0C);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        check8("tx_valid rst", 8'h00, {7'h00, tx_valid});
        check8("reg_addr rst", 8'h00, reg_addr[15:8]);
        run_row(rows[6]);
        test_done();
    end
endmodule
`default_nettype wire
